// ===== hdl/adl_top.sv
// alarm delay qualification and loop fault detection with AXI4-Lite registers
// Summary of operation
// - each of three alarms has its own on delay and off delay
// - alarm 1 delays apply to its own function; OR-ed extra alarms pass undelayed
// - delayed alarm state also drives indicator and status bit
// - on delay also qualifies after power-up and leaving initial setting level
// - initial setting level or converter error: delayed alarm states off at once, no off delay
// - alarm sets only after raw stays active longer than on delay
// - alarm clears only after raw stays inactive longer than off delay
// - raw toggle during a delay restarts the timer from the latest change
// - delays are 0 to 999 s, default 0, zero meaning no delay
// - delays count only for alarm types other than 0, 12 and 13
// - loop fault sets when large deviation fails to shrink by band in detect time
// - deviation within level threshold never sets the loop fault
// - loop fault clears on enough reduction, sets again on a short one
// - detection time 0 to 9999 s; zero disables loop fault detection
// - level threshold limited to its range, default 8.0
// - band limited to its range, default 3.0
// - loop fault reaches an alarm output only as alarm 1 type 12; LOOP_FAULT carries it directly
// - no detection during ramp, tuning, manual, stop or remote set point
// - with alarm 1 latch enabled a loop fault stays latched on
// - eight detection times, one per PID set; active set's time is used
// - auto-tuning writes detection time into tuned set unless heating/cooling
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module adl_top
    import adl_pkg::*;
#(
    parameter int TICK_CYCLES = adl_pkg::TICK_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [adl_pkg::NUM_ALARMS-1:0] RAW_ALARM,
    input wire logic OTHER_ALARM1,
    input wire logic AD_ERROR,
    input wire logic INIT_LEVEL,
    input wire logic DEV_VALID,
    input wire logic signed [adl_pkg::LVL_W-1:0] DEV_DATA,
    input wire logic RAMPING,
    input wire logic AUTOTUNE,
    input wire logic MANUAL,
    input wire logic STOPPED,
    input wire logic REMOTE_SP,
    input wire logic HEAT_COOL,
    input wire logic AT_DONE,
    input wire logic [adl_pkg::DET_W-1:0] AT_TIME,
    output logic [adl_pkg::NUM_ALARMS-1:0] ALARM_OUT,
    output logic [adl_pkg::NUM_ALARMS-1:0] INDICATOR,
    output logic LOOP_FAULT
);
    import adl_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [TW-1:0] sec_cnt_r;
    logic tick_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r, rd_mux;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic do_write, wr_map, rd_map;
    logic [7:0] ctrl_r;
    logic [TYPE_W-1:0] type_r [NUM_ALARMS];
    logic [LVL_W-1:0] level_r, band_r, dev_abs_r, ref_r;
    logic [DLY_W-1:0] on_r [NUM_ALARMS];
    logic [DLY_W-1:0] off_r [NUM_ALARMS];
    logic [DET_W-1:0] det_r [NUM_PID_SETS];
    logic [DET_W-1:0] det_cur, lf_cnt_r;
    logic [2:0] pid_set;
    logic latch_en, latch_clr, suppress, lf_en, lf_r, lf_latch_r, lf_out, force_off;
    logic [NUM_ALARMS-1:0] raw_sel, alarm_q;
    logic [LVL_W:0] ref_need;

    // byte-lane merge of a write into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    // true for every decoded register byte address
    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_TYPE || a == ADDR_LEVEL
            || a == ADDR_BAND || (a[7:4] == ADDR_ON0[7:4] && a[3:2] != 2'h3 && a[1:0] == 2'h0)
            || (a[7:4] == ADDR_OFF0[7:4] && a[3:2] != 2'h3 && a[1:0] == 2'h0)
            || (a[7:5] == ADDR_DET0[7:5] && a[1:0] == 2'h0);
    endfunction

    // one-second prescaler; long count so simulation can shorten it
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sec_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (sec_cnt_r == TW'(TICK_CYCLES - 1)) begin
            sec_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            sec_cnt_r <= sec_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // write address and data are taken in either order, held until the response
    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wr_map = mapped(awaddr_r);
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // control and type registers; unused type bits are not stored
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        logic [31:0] v;
        v = 32'h0;
        if (!RST_N) begin
            ctrl_r <= 8'h00;
            for (int i = 0; i < NUM_ALARMS; i++) type_r[i] <= TYPE_NONE;
        end else if (do_write && awaddr_r == ADDR_CTRL) begin
            v = merge({24'h0, ctrl_r}, wdata_r, wstrb_r) & 32'h0000_0071;
            ctrl_r <= v[7:0];
        end else if (do_write && awaddr_r == ADDR_TYPE) begin
            v = merge({12'h0, type_r[2], 4'h0, type_r[1], 4'h0, type_r[0]}, wdata_r, wstrb_r);
            for (int i = 0; i < NUM_ALARMS; i++) type_r[i] <= v[TYPE_STRIDE*i +: TYPE_W];
        end
    end

    assign latch_en = ctrl_r[CTRL_LATCH_BIT];
    assign pid_set = ctrl_r[CTRL_SET_LSB +: 3];
    assign latch_clr = do_write && awaddr_r == ADDR_STATUS && wstrb_r[0]
                       && wdata_r[STAT_LATCH_BIT];

    // level and band are limited to their ranges on every write
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        logic [31:0] v;
        v = 32'h0;
        if (!RST_N) begin
            level_r <= LVL_RST;
            band_r <= BAND_RST;
        end else if (do_write && awaddr_r == ADDR_LEVEL) begin
            v = merge({16'h0, level_r}, wdata_r, wstrb_r);
            level_r <= v < 32'(LVL_MIN) ? LVL_MIN
                       : v > 32'(LVL_MAX) ? LVL_MAX : v[LVL_W-1:0];
        end else if (do_write && awaddr_r == ADDR_BAND) begin
            v = merge({16'h0, band_r}, wdata_r, wstrb_r);
            band_r <= v > 32'(LVL_MAX) ? LVL_MAX : v[LVL_W-1:0];
        end
    end

    // on and off delay settings, at most 999 s each
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        logic [31:0] v;
        v = 32'h0;
        if (!RST_N) begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                on_r[i] <= DLY_RST;
                off_r[i] <= DLY_RST;
            end
        end else if (do_write && wr_map && awaddr_r[7:4] == ADDR_ON0[7:4]) begin
            v = merge({22'h0, on_r[awaddr_r[3:2]]}, wdata_r, wstrb_r);
            on_r[awaddr_r[3:2]] <= v > 32'(DLY_MAX) ? DLY_MAX : v[DLY_W-1:0];
        end else if (do_write && wr_map && awaddr_r[7:4] == ADDR_OFF0[7:4]) begin
            v = merge({22'h0, off_r[awaddr_r[3:2]]}, wdata_r, wstrb_r);
            off_r[awaddr_r[3:2]] <= v > 32'(DLY_MAX) ? DLY_MAX : v[DLY_W-1:0];
        end
    end

    // per-set detection times; a finished tuning run wins over a bus write
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        logic [31:0] v;
        v = 32'h0;
        if (!RST_N) begin
            for (int i = 0; i < NUM_PID_SETS; i++) det_r[i] <= DET_RST;
        end else if (AT_DONE && !HEAT_COOL) begin
            det_r[pid_set] <= AT_TIME > DET_MAX ? DET_MAX : AT_TIME;
        end else if (do_write && wr_map && awaddr_r[7:5] == ADDR_DET0[7:5]) begin
            v = merge({18'h0, det_r[awaddr_r[4:2]]}, wdata_r, wstrb_r);
            det_r[awaddr_r[4:2]] <= v > 32'(DET_MAX) ? DET_MAX : v[DET_W-1:0];
        end
    end

    // read data mux; unmapped reads return zero with an error response
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (S_AXI_ARADDR[7:4])
            4'h0: begin
                if (S_AXI_ARADDR[3:0] == ADDR_CTRL[3:0]) rd_mux = {24'h0, ctrl_r};
                if (S_AXI_ARADDR[3:0] == ADDR_STATUS[3:0])
                    rd_mux = {27'h0, lf_latch_r, lf_r, alarm_q};
                if (S_AXI_ARADDR[3:0] == ADDR_TYPE[3:0])
                    rd_mux = {12'h0, type_r[2], 4'h0, type_r[1], 4'h0, type_r[0]};
                if (S_AXI_ARADDR[3:0] == ADDR_LEVEL[3:0]) rd_mux = {16'h0, level_r};
            end
            4'h1: rd_mux = {16'h0, band_r};
            4'h2: rd_mux = S_AXI_ARADDR[3:2] == 2'h3 ? 32'h0 : {22'h0, on_r[S_AXI_ARADDR[3:2]]};
            4'h3: rd_mux = S_AXI_ARADDR[3:2] == 2'h3 ? 32'h0 : {22'h0, off_r[S_AXI_ARADDR[3:2]]};
            4'h4, 4'h5: rd_mux = {18'h0, det_r[S_AXI_ARADDR[4:2]]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign rd_map = mapped(S_AXI_ARADDR);
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    // read channel: one registered answer per address
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_map ? rd_mux : 32'h0000_0000;
            rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // magnitude of the latest deviation sample
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dev_abs_r <= '0;
        end else if (DEV_VALID) begin
            dev_abs_r <= DEV_DATA[LVL_W-1] ? LVL_W'(-DEV_DATA) : DEV_DATA;
        end
    end

    assign det_cur = det_r[pid_set];
    assign suppress = RAMPING || AUTOTUNE || MANUAL || STOPPED || REMOTE_SP;
    assign force_off = INIT_LEVEL || AD_ERROR;
    assign lf_en = det_cur != '0 && !suppress;
    assign ref_need = {1'b0, dev_abs_r} + {1'b0, band_r};

    // loop fault: judge the reduction at the end of each detection interval
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lf_r <= 1'b0;
            lf_cnt_r <= '0;
            ref_r <= '0;
        end else if (!lf_en || dev_abs_r <= level_r) begin
            lf_r <= 1'b0;
            lf_cnt_r <= '0;
            ref_r <= dev_abs_r;
        end else if (tick_r) begin
            if (lf_cnt_r + 1'b1 >= det_cur) begin
                lf_cnt_r <= '0;
                ref_r <= dev_abs_r;
                // enough reduction clears, a short one sets again
                lf_r <= {1'b0, ref_r} < ref_need;
            end else begin
                lf_cnt_r <= lf_cnt_r + 1'b1;
            end
        end
    end

    // latch holds a loop fault until software clears it; a new fault wins
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lf_latch_r <= 1'b0;
        end else if (latch_en && lf_r) begin
            lf_latch_r <= 1'b1;
        end else if (latch_clr || !latch_en) begin
            lf_latch_r <= 1'b0;
        end
    end

    assign lf_out = lf_r || lf_latch_r;

    // per-channel raw select and delay qualification
    generate
        for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_ch
            logic use_dly;
            assign use_dly = type_r[i] != TYPE_NONE && type_r[i] != TYPE_LOOP
                             && type_r[i] != TYPE_RATE;
            // type 12 routes the loop fault only on channel 1
            assign raw_sel[i] = type_r[i] == TYPE_NONE ? 1'b0
                              : type_r[i] == TYPE_LOOP ? (i == 0 ? lf_out : 1'b0)
                              : RAW_ALARM[i];
            adl_delay #(.DW(DLY_W)) u_dly (
                .clk(SYS_CLK),
                .rst_n(RST_N),
                .tick(tick_r),
                .force_off(force_off),
                .raw(raw_sel[i]),
                .on_dly(use_dly ? on_r[i] : DLY_RST),
                .off_dly(use_dly ? off_r[i] : DLY_RST),
                .q(alarm_q[i])
            );
        end
    endgenerate

    // outputs; extra alarm 1 sources bypass the delay
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ALARM_OUT <= '0;
            INDICATOR <= '0;
            LOOP_FAULT <= 1'b0;
        end else begin
            ALARM_OUT <= {alarm_q[2:1], alarm_q[0] | OTHER_ALARM1};
            INDICATOR <= {alarm_q[2:1], alarm_q[0] | OTHER_ALARM1};
            LOOP_FAULT <= lf_out;
        end
    end

    property p_force;
        @(posedge SYS_CLK) disable iff (!RST_N)
        force_off ##1 force_off |=> ALARM_OUT[2:1] == 2'b00 && ALARM_OUT[0] == $past(OTHER_ALARM1);
    endproperty
    a_force: assert property (p_force) else $error("alarms not forced off");

    property p_other;
        @(posedge SYS_CLK) disable iff (!RST_N)
        OTHER_ALARM1 |=> ALARM_OUT[0] && INDICATOR[0];
    endproperty
    a_other: assert property (p_other) else $error("extra alarm 1 source was delayed");

    property p_ind;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ##1 INDICATOR == ALARM_OUT && ALARM_OUT[2:1] == $past(alarm_q[2:1]);
    endproperty
    a_ind: assert property (p_ind) else $error("indicator differs from alarm");

    property p_det0;
        @(posedge SYS_CLK) disable iff (!RST_N)
        det_cur == '0 |=> !lf_r;
    endproperty
    a_det0: assert property (p_det0) else $error("loop fault with detection off");

    property p_level;
        @(posedge SYS_CLK) disable iff (!RST_N)
        dev_abs_r <= level_r |=> !lf_r;
    endproperty
    a_level: assert property (p_level) else $error("loop fault inside level");

    property p_suppress;
        @(posedge SYS_CLK) disable iff (!RST_N)
        suppress |=> !lf_r ##1 (!LOOP_FAULT || $past(lf_latch_r));
    endproperty
    a_suppress: assert property (p_suppress) else $error("loop fault while suppressed");

    property p_latch;
        @(posedge SYS_CLK) disable iff (!RST_N)
        lf_latch_r && latch_en && !latch_clr |=> lf_latch_r ##1 LOOP_FAULT;
    endproperty
    a_latch: assert property (p_latch) else $error("latched loop fault dropped");

    property p_type12;
        @(posedge SYS_CLK) disable iff (!RST_N)
        type_r[1] == TYPE_LOOP && !alarm_q[1] |=> !alarm_q[1];
    endproperty
    a_type12: assert property (p_type12) else $error("type 12 acted on alarm 2");

    property p_tune;
        @(posedge SYS_CLK) disable iff (!RST_N)
        AT_DONE && !HEAT_COOL && AT_TIME <= DET_MAX |=> det_r[$past(pid_set)] == $past(AT_TIME);
    endproperty
    a_tune: assert property (p_tune) else $error("tuning result not stored");

    property p_judge;
        @(posedge SYS_CLK) disable iff (!RST_N)
        lf_en && dev_abs_r > level_r && tick_r && lf_cnt_r + 1'b1 >= det_cur
            |=> lf_r == ($past({1'b0, ref_r}) < $past(ref_need));
    endproperty
    a_judge: assert property (p_judge) else $error("loop fault judged wrongly");
endmodule

// ===== inc/adl_pkg.sv
// constants shared by the alarm delay and loop fault block
package adl_pkg;
    // timing: one-second tick from the system clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1_000_000_000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // sizes
    localparam int NUM_ALARMS = 3;
    localparam int NUM_PID_SETS = 8;
    localparam int DLY_W = 10;
    localparam int DET_W = 14;
    localparam int LVL_W = 16;
    localparam int TYPE_W = 4;
    // setting limits and values after reset
    localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E7;
    localparam logic [DLY_W-1:0] DLY_RST = 10'h000;
    localparam logic [DET_W-1:0] DET_MAX = 14'h270F;
    localparam logic [DET_W-1:0] DET_RST = 14'h0000;
    localparam logic [LVL_W-1:0] LVL_MIN = 16'h0001;
    localparam logic [LVL_W-1:0] LVL_MAX = 16'h7E90;
    localparam logic [LVL_W-1:0] LVL_RST = 16'h0050;
    localparam logic [LVL_W-1:0] BAND_RST = 16'h001E;
    // alarm type codes
    localparam logic [TYPE_W-1:0] TYPE_NONE = 4'h0;
    localparam logic [TYPE_W-1:0] TYPE_LOOP = 4'hC;
    localparam logic [TYPE_W-1:0] TYPE_RATE = 4'hD;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TYPE = 8'h08;
    localparam logic [7:0] ADDR_LEVEL = 8'h0C;
    localparam logic [7:0] ADDR_BAND = 8'h10;
    localparam logic [7:0] ADDR_ON0 = 8'h20;
    localparam logic [7:0] ADDR_OFF0 = 8'h30;
    localparam logic [7:0] ADDR_DET0 = 8'h40;
    // field positions
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_SET_LSB = 4;
    localparam int STAT_LF_BIT = 3;
    localparam int STAT_LATCH_BIT = 4;
    localparam int TYPE_STRIDE = 8;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/adl_delay.sv
// on/off delay qualifier for one alarm channel
`timescale 1ns/1ns
module adl_delay #(
    parameter int DW = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic force_off,
    input wire logic raw,
    input wire logic [DW-1:0] on_dly,
    input wire logic [DW-1:0] off_dly,
    output logic q
);
    logic [DW-1:0] cnt_r;
    logic [DW-1:0] dly;

    // delay that applies to the pending change
    assign dly = q ? off_dly : on_dly;

    // qualified state; counts whole ticks since the latest raw transition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
            cnt_r <= '0;
        end else if (force_off) begin
            q <= 1'b0;
            cnt_r <= '0;
        end else if (raw == q) begin
            cnt_r <= '0;
        end else if (dly == '0) begin
            q <= raw;
            cnt_r <= '0;
        end else if (tick) begin
            // switch on the tick that makes the elapsed time exceed the delay
            if (cnt_r == dly) begin
                q <= raw;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    property p_on_time;
        @(posedge clk) disable iff (!rst_n)
        $rose(q) && $past(on_dly) != '0 |-> $past(cnt_r) == $past(on_dly) && $past(tick);
    endproperty
    a_on_time: assert property (p_on_time) else $error("alarm set before on delay ran out");

    property p_off_time;
        @(posedge clk) disable iff (!rst_n)
        $fell(q) && !$past(force_off) && $past(off_dly) != '0
            |-> $past(cnt_r) == $past(off_dly) && $past(tick);
    endproperty
    a_off_time: assert property (p_off_time) else $error("alarm cleared before off delay");

    property p_zero_dly;
        @(posedge clk) disable iff (!rst_n)
        !force_off && raw && !q && on_dly == '0 |=> q;
    endproperty
    a_zero_dly: assert property (p_zero_dly) else $error("zero on delay did not pass alarm");

    property p_restart;
        @(posedge clk) disable iff (!rst_n)
        !q && !raw ##1 raw && !force_off |-> cnt_r == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("delay timer did not restart");
endmodule

// ===== dv/adl_fw.sv
// firmware model: strobes deviation samples every four cycles
`timescale 1ns/1ns
module adl_fw (
    input wire logic clk,
    input wire logic [15:0] dev,
    output logic dv,
    output logic [15:0] dd
);
    logic [1:0] c_r = 2'h0;
    // data is inverted off the strobe so a stale sample is never trusted
    always @(posedge clk) begin
        c_r <= c_r + 2'h1;
        dv <= &c_r;
        dd <= &c_r ? dev : ~dev;
    end
endmodule

// ===== dv/tb_top.sv
// bench: bus tasks and scenario tasks for the alarm block
`timescale 1ns/1ns
module tb_top;
    import adl_pkg::*;
    logic clk, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, oth = 1'b0, ini = 1'b0;
    logic ade = 1'b0, hc = 1'b0, atd = 1'b0, awr, wrd, bvl, arr, rvl, lf, dv;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdt, d;
    logic [1:0] rrs, rs, brs, bs;
    logic [2:0] raw = 3'h0, ao, ind;
    logic [4:0] sup = 5'h0;
    logic [13:0] att = 14'h0;
    logic [15:0] dev = 16'h0, dd;
    int n_errors = 0, cmp_count = 0;
    adl_fw adl_fw_inst (.clk(clk), .dev(dev), .dv(dv), .dd(dd));
    adl_top #(.TICK_CYCLES(10)) adl_top_inst (.SYS_CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(brs),
        .S_AXI_BVALID(bvl), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rvl),
        .S_AXI_RREADY(1'b1), .RAW_ALARM(raw), .OTHER_ALARM1(oth), .AD_ERROR(ade),
        .INIT_LEVEL(ini), .DEV_VALID(dv), .DEV_DATA(dd), .RAMPING(sup[0]),
        .AUTOTUNE(sup[1]), .MANUAL(sup[2]), .STOPPED(sup[3]), .REMOTE_SP(sup[4]),
        .HEAT_COOL(hc), .AT_DONE(atd), .AT_TIME(att), .ALARM_OUT(ao), .INDICATOR(ind),
        .LOOP_FAULT(lf));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // a bus wait that ran out ends the run
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask
    // each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bvl) break;
        end
        tmo(bvl);
        bs = brs;
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rvl) break;
        end
        tmo(rvl);
        d = rdt;
        rs = rrs;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic s_regs();
        rd(ADDR_LEVEL);
        chk("level", 32'h50, d);
        rd(ADDR_BAND);
        chk("band", 32'h1E, d);
        rd(ADDR_ON0 + 8'h4);
        chk("on2", 32'h0, d);
        wr(ADDR_ON0, 32'hFFFF);
        chk("bresp", 32'h0, 32'(bs));
        rd(ADDR_ON0);
        chk("on1", 32'h3E7, d);
        wr(ADDR_DET0, 32'hFFFF);
        rd(ADDR_DET0);
        chk("det", 32'h270F, d);
        rd(8'hFC);
        chk("unmapped", 32'h2, 32'(rs));
        wr(8'hFC, 32'h1);
        chk("unmapped wr", 32'h2, 32'(bs));
    endtask
    // ticks every 10 cycles: 19 edges hold at most two ticks, 32 at least three
    task automatic s_delay();
        wr(ADDR_TYPE, 32'h000D0100);
        wr(ADDR_ON0 + 8'h4, 32'h2);
        wr(ADDR_OFF0 + 8'h4, 32'h1);
        wr(ADDR_ON0 + 8'h8, 32'h5);
        raw <= 3'b110;
        cyc(15);
        raw <= 3'b100;
        cyc(1);
        raw <= 3'b110;
        cyc(19);
        chk("on early", 32'h4, 32'(ao));
        cyc(13);
        chk("on late", 32'h36, 32'({ind, ao}));
        rd(ADDR_STATUS);
        chk("status", 32'h6, d & 32'h7);
        ini <= 1'b1;
        cyc(3);
        chk("forced", 32'h0, 32'(ao));
        ini <= 1'b0;
        cyc(19);
        chk("reentry", 32'h4, 32'(ao));
        cyc(13);
        chk("reentry", 32'h6, 32'(ao));
        raw <= 3'b000;
        cyc(9);
        chk("off early", 32'h2, 32'(ao));
        cyc(13);
        chk("off late", 32'h0, 32'(ao));
        oth <= 1'b1;
        cyc(3);
        chk("other", 32'h1, 32'(ao));
        oth <= 1'b0;
    endtask
    task automatic s_loop();
        wr(ADDR_TYPE, 32'hC0C);
        raw <= 3'b010;
        wr(ADDR_DET0, 32'h2);
        dev <= 16'h0100;
        repeat (90) if (lf !== 1'b1) @(posedge clk);
        tmo(lf);
        cyc(1);
        chk("lf", 32'h9, 32'({lf, ao}));
        dev <= 16'h00C0;
        repeat (90) if (lf !== 1'b0) @(posedge clk);
        tmo(!lf);
        chk("lf clear", 32'h0, 32'(lf));
        repeat (90) if (lf !== 1'b1) @(posedge clk);
        tmo(lf);
        for (int i = 0; i < 5; i++) begin
            sup <= 5'(1 << i);
            cyc(3);
            chk("suppress", 32'h0, 32'(lf));
            sup <= 5'h0;
            repeat (90) if (lf !== 1'b1) @(posedge clk);
            tmo(lf);
        end
        wr(ADDR_CTRL, 32'h1);
        dev <= 16'h0010;
        cyc(8);
        rd(ADDR_STATUS);
        chk("latch", 32'h10, d & 32'h18);
        chk("latch", 32'h1, 32'(lf));
        wr(ADDR_STATUS, 32'h10);
        cyc(3);
        chk("unlatch", 32'h0, 32'(lf));
        dev <= 16'h0100;
        repeat (90) if (lf !== 1'b1) @(posedge clk);
        tmo(lf);
        wr(ADDR_CTRL, 32'h10);
        cyc(3);
        chk("set1 off", 32'h0, 32'(lf));
    endtask
    // second result arrives under heating/cooling and must be dropped
    task automatic s_tune();
        att <= 14'h5;
        atd <= 1'b1;
        cyc(1);
        atd <= 1'b0;
        hc <= 1'b1;
        cyc(1);
        att <= 14'h7;
        atd <= 1'b1;
        cyc(1);
        atd <= 1'b0;
        rd(ADDR_DET0 + 8'h4);
        chk("tuned", 32'h5, d);
    endtask
    // reset for four cycles, then the scenarios in turn
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        s_regs();
        s_delay();
        s_loop();
        s_tune();
        results();
    end
endmodule
